/* core/plr_port.sv */
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "plr_consts.svh"
// Notes on behaviour
// - Control codes: 00 idle, 01 status, 10 receive, 11 grant.
// - Requests start with 1, end with 0, MSB first, line idles low.
// - Status word: four flags bits 0-3, address 4-7, data 8-15.
// - Register write is 17 bits: type 101, address, byte, stop.
// - Acceleration control is 6 bits, type 110, bit 4 enables.
// - Driving receive discards pending fair or priority requests.
// - Fair or priority request overlapping receive is ignored.
// - Isochronous request stays pending until won or bus reset.
// - Pending immediate request is granted as soon as reception ends.
// - Only one bus request pending; new ones ignored meanwhile.
// - Bus reset clears every pending bus request.
// - Register write applied as soon as the stream is complete.
// - Register read answered by status transfer, retried until delivered.
// - Register requests accepted anytime; reads ignored while one is outstanding.
// - Bus reset keeps a pending register read.
// - Acceleration active only with enable bit in register 5 set.
// - Acceleration control acts at once; reset or iso request re-enables.
// - Status starts only from idle, drives 01, two bits per cycle.
// - Status is 2 cycles for flags, 8 cycles with register data.
// - After self-identification the node address register is sent in full.
// - Arriving packet cuts status short, straight to receive.
// - Flags delivered when sent; register only after all eight bits.
// - At least one idle cycle between status transfers.
// - Completed status may go straight to grant with bus reset pending.
module plr_port
  import plr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_request_line,
  input  wire logic [1:0]  ctl_in,
  output logic      [1:0]  interface_control_lines,
  output logic             ctl_oe_n,
  output logic      [7:0]  interface_data_lines,
  output logic             data_oe_n,
  input  wire logic        rx_active,
  input  wire logic [7:0]  rx_data,
  input  wire logic        bus_won,
  input  wire logic        bus_lost,
  input  wire logic        bus_reset,
  input  wire logic        bus_reset_pending,
  input  wire logic        selfid_done,
  input  wire logic        arb_reset_gap,
  input  wire logic        subaction_gap,
  input  wire logic        phy_interrupt,
  output plr_busreq_t      bus_request,
  output logic             acceleration_feature_enable
);

  plr_state_t  s;
  plr_state_t  n;
  logic [16:0] nsh;
  logic [4:0]  ncnt;
  logic [4:0]  len;
  logic [2:0]  kind;
  logic        done;
  logic        accept;
  logic [3:0]  st_addr;
  logic [2:0]  st_last;

  always_comb begin
    n = s;
    nsh = {s.rq_sh[15:0], link_request_line};
    ncnt = s.rq_cnt + 5'h01;
    kind = s.rq_kind;
    len = `PLR_LEN_ACC;
    done = 1'b0;
    st_addr = `PLR_PHYID_REG;
    st_last = `PLR_ST_LAST_SHORT;
    accept = hsel && htrans[1] && hready;

    // Bus slave: one wait state so read data comes from a flop
    if (s.ahb_dp && !s.ahb_dp2) begin
      n.ahb_dp2 = 1'b1;
      n.rdata = 32'h0;
      if (s.ahb_hit && s.ahb_wr) begin
        if (s.ahb_addr == `PLR_AHB_CTRL) begin
          n.link_en = hwdata[0];
        end else if (s.ahb_addr[7:6] == `PLR_AHB_PHYREG && s.ahb_addr[1:0] == 2'h0) begin
          n.regs[s.ahb_addr[5:2]] = hwdata[7:0];
        end
      end else if (s.ahb_hit) begin
        if (s.ahb_addr == `PLR_AHB_CTRL) begin
          n.rdata = {31'h0, s.link_en};
        end else if (s.ahb_addr == `PLR_AHB_STATUS) begin
          n.rdata = {19'h0, s.auto_pend, s.flags, s.mode, acceleration_feature_enable,
                     s.rd_pend, s.req.valid, s.req.kind};
        end else if (s.ahb_addr[7:6] == `PLR_AHB_PHYREG && s.ahb_addr[1:0] == 2'h0) begin
          n.rdata = {24'h0, s.regs[s.ahb_addr[5:2]]};
        end
      end
    end
    if (!s.ahb_dp || s.ahb_dp2) begin
      n.ahb_dp = accept;
      n.ahb_dp2 = 1'b0;
      n.ahb_wr = hwrite;
      n.ahb_hit = (haddr[31:8] == 24'h0);
      n.ahb_addr = haddr[7:0];
    end

    // Request line shifter, one bit per clock
    if (s.rq_busy) begin
      n.rq_sh = nsh;
      n.rq_cnt = ncnt;
      if (s.mode == md_recv) begin
        n.rq_ovl = 1'b1;
      end
      if (s.rq_cnt == `PLR_LEN_TYPE) begin
        kind = nsh[2:0];
        n.rq_kind = kind;
      end
      unique case (kind)
        `PLR_RT_IMM, `PLR_RT_ISO, `PLR_RT_PRI, `PLR_RT_FAIR: begin
          // Stop bit may be omitted when the last speed bit is zero
          if (ncnt == `PLR_LEN_BUS_SHORT && !link_request_line) begin
            len = `PLR_LEN_BUS_SHORT;
          end else begin
            len = `PLR_LEN_BUS;
          end
        end
        `PLR_RT_RD: len = `PLR_LEN_RD;
        `PLR_RT_WR: len = `PLR_LEN_WR;
        default: len = `PLR_LEN_ACC;
      endcase
      done = (s.rq_cnt > `PLR_LEN_TYPE) && (ncnt == len);
      if (done) begin
        n.rq_busy = 1'b0;
      end
    end else if (link_request_line && s.link_en) begin
      n.rq_busy = 1'b1;
      n.rq_cnt = 5'h01;
      n.rq_sh = {16'h0, 1'b1};
      n.rq_ovl = (s.mode == md_recv);
      n.rq_kind = 3'h0;
    end

    if (done) begin
      unique case (kind)
        `PLR_RT_IMM, `PLR_RT_ISO, `PLR_RT_PRI, `PLR_RT_FAIR: begin
          if (!s.req.valid && !(kind[2:1] == 2'h1 && n.rq_ovl)) begin
            n.req.valid = 1'b1;
            n.req.kind = kind;
            n.req.speed = (ncnt == `PLR_LEN_BUS_SHORT) ? nsh[2:0] : nsh[3:1];
            if (kind == `PLR_RT_ISO) begin
              n.accel_on = 1'b1;
            end
          end
        end
        `PLR_RT_RD: begin
          if (!s.rd_pend) begin
            n.rd_pend = 1'b1;
            n.rd_addr = nsh[4:1];
          end
        end
        `PLR_RT_WR: n.regs[nsh[12:9]] = nsh[8:1];
        `PLR_RT_ACC: n.accel_on = nsh[1];
        default: n.rq_kind = kind;
      endcase
    end

    // Arbitration results from the cable side
    if (bus_lost && s.req.valid && s.req.kind != `PLR_RT_ISO) begin
      n.req.valid = 1'b0;
    end
    if (bus_won && s.req.valid) begin
      n.req.valid = 1'b0;
      n.won_wait = 1'b1;
    end
    // Interface control line sequencing
    unique case (s.mode)
      md_idle: begin
        if (rx_active) begin
          n.mode = md_recv;
        end else if (s.won_wait) begin
          n.mode = md_grant;
          n.won_wait = 1'b0;
          n.gfirst = 1'b1;
        end else if (|s.flags || s.rd_pend || s.auto_pend) begin
          n.mode = md_stat;
          n.st_full = s.rd_pend || s.auto_pend;
          n.st_rd = s.rd_pend;
          if (s.rd_pend) begin
            st_addr = s.rd_addr;
          end
          n.st_word = {s.regs[st_addr], st_addr, s.flags};
          n.st_idx = 3'h0;
        end
      end
      md_stat: begin
        // Flags count as delivered the cycle they are on the lines
        if (s.st_idx == 3'h0) begin
          n.flags[1:0] = s.flags[1:0] & ~s.st_word[1:0];
        end else if (s.st_idx == 3'h1) begin
          n.flags[3:2] = s.flags[3:2] & ~s.st_word[3:2];
        end
        st_last = s.st_full ? `PLR_ST_LAST_FULL : `PLR_ST_LAST_SHORT;
        if (rx_active) begin
          n.mode = md_recv;
        end else if (s.st_idx == st_last) begin
          if (s.st_full && s.st_rd) begin
            n.rd_pend = 1'b0;
          end else if (s.st_full) begin
            n.auto_pend = 1'b0;
          end
          if (bus_reset_pending && n.won_wait) begin
            n.mode = md_grant;
            n.won_wait = 1'b0;
            n.gfirst = 1'b1;
          end else begin
            n.mode = md_idle;
          end
        end else begin
          n.st_idx = s.st_idx + 3'h1;
        end
      end
      md_recv: begin
        if (!rx_active) begin
          if (n.req.valid && n.req.kind == `PLR_RT_IMM) begin
            n.req.valid = 1'b0;
            n.mode = md_grant;
            n.gfirst = 1'b1;
          end else begin
            n.mode = md_idle;
          end
        end
      end
      md_grant: begin
        // Link hands back by driving idle; covers a cancelled acknowledge
        if (s.gfirst) begin
          n.gfirst = 1'b0;
        end else if (ctl_in == `PLR_CTL_IDLE) begin
          n.mode = md_idle;
        end
      end
    endcase

    if (n.mode == md_recv && n.req.valid && n.req.kind[2:1] == 2'h1) begin
      n.req.valid = 1'b0;
    end
    // Bus reset leaves a pending register read in place
    if (bus_reset) begin
      n.req.valid = 1'b0;
      n.won_wait = 1'b0;
      n.accel_on = 1'b1;
    end
    // Events set after the clears so a same-cycle event is kept
    n.flags = n.flags | {phy_interrupt, bus_reset, subaction_gap, arb_reset_gap};
    if (selfid_done) begin
      n.auto_pend = 1'b1;
    end

    n.oe_n = 1'b0;
    n.dat = 8'h0;
    unique case (n.mode)
      md_idle: n.ctl = `PLR_CTL_IDLE;
      md_stat: begin
        n.ctl = `PLR_CTL_STAT;
        n.dat = {6'h0, n.st_word[{n.st_idx, 1'b1}], n.st_word[{n.st_idx, 1'b0}]};
      end
      md_recv: begin
        n.ctl = `PLR_CTL_RECV;
        n.dat = rx_data;
      end
      md_grant: begin
        n.ctl = `PLR_CTL_GRNT;
        n.oe_n = !n.gfirst;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.accel_on <= `PLR_ACCEL_RST;
      s.link_en <= `PLR_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = !(s.ahb_dp && !s.ahb_dp2);
  assign hresp = 1'b0;
  assign interface_control_lines = s.ctl;
  assign ctl_oe_n = s.oe_n;
  assign interface_data_lines = s.dat;
  assign data_oe_n = s.oe_n;
  assign bus_request = s.req;
  // Feature is live only while both the link and software allow it
  assign acceleration_feature_enable = s.accel_on && s.regs[`PLR_EAA_REG][`PLR_EAA_BIT];

endmodule // plr_port

/* core/plr_consts.svh */
`ifndef PLR_CONSTS_SVH
`define PLR_CONSTS_SVH
`define PLR_CTL_IDLE 2'h0
`define PLR_CTL_STAT 2'h1
`define PLR_CTL_RECV 2'h2
`define PLR_CTL_GRNT 2'h3
`define PLR_RT_IMM 3'h0
`define PLR_RT_ISO 3'h1
`define PLR_RT_PRI 3'h2
`define PLR_RT_FAIR 3'h3
`define PLR_RT_RD 3'h4
`define PLR_RT_WR 3'h5
`define PLR_RT_ACC 3'h6
`define PLR_LEN_TYPE 5'h03
`define PLR_LEN_BUS 5'h08
`define PLR_LEN_BUS_SHORT 5'h07
`define PLR_LEN_RD 5'h09
`define PLR_LEN_WR 5'h11
`define PLR_LEN_ACC 5'h06
`define PLR_EAA_REG 4'h5
`define PLR_EAA_BIT 3'h0
`define PLR_PHYID_REG 4'h0
`define PLR_ST_LAST_SHORT 3'h1
`define PLR_ST_LAST_FULL 3'h7
`define PLR_AHB_CTRL 8'h00
`define PLR_AHB_STATUS 8'h04
`define PLR_AHB_PHYREG 2'h1
`define PLR_CTRL_RST 1'h1
`define PLR_ACCEL_RST 1'h1
`endif

/* core/plr_pkg.sv */
package plr_pkg;

  typedef enum logic [1:0] {
    md_idle,
    md_stat,
    md_recv,
    md_grant
  } plr_mode_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] kind;
    logic [2:0] speed;
  } plr_busreq_t;

  typedef struct packed {
    plr_mode_t        mode;
    logic [1:0]       ctl;
    logic             oe_n;
    logic [7:0]       dat;
    logic             gfirst;
    logic             won_wait;
    plr_busreq_t      req;
    logic             rq_busy;
    logic [4:0]       rq_cnt;
    logic [16:0]      rq_sh;
    logic [2:0]       rq_kind;
    logic             rq_ovl;
    logic [15:0][7:0] regs;
    logic [3:0]       flags;
    logic             rd_pend;
    logic [3:0]       rd_addr;
    logic             auto_pend;
    logic [15:0]      st_word;
    logic [2:0]       st_idx;
    logic             st_full;
    logic             st_rd;
    logic             accel_on;
    logic             link_en;
    logic             ahb_dp;
    logic             ahb_dp2;
    logic             ahb_wr;
    logic             ahb_hit;
    logic [7:0]       ahb_addr;
    logic [31:0]      rdata;
  } plr_state_t;

endpackage

/* verif/plr_link_model.sv */
`timescale 1ns/1ns
module plr_link_model (
  input  wire logic       hclk,
  input  wire logic       ctl_oe_n,
  input  wire logic [1:0] ctl_dev,
  output logic            link_request_line,
  output logic      [1:0] ctl_in
);
  // Link hands the lines back at once, so a released bus reads idle
  assign ctl_in = ctl_oe_n ? 2'h0 : ctl_dev;
  initial link_request_line = 1'h0;
  task send(input logic [16:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_request_line <= v[i];
      @(posedge hclk);
    end
    link_request_line <= 1'h0;
  endtask
endmodule // plr_link_model

/* verif/plr_port_checker.sv */
`timescale 1ns/1ns
`include "plr_consts.svh"
module plr_port_checker
  import plr_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [1:0]  interface_control_lines,
  input wire logic        rx_active,
  input wire logic        bus_won,
  input wire logic        bus_reset,
  input wire plr_busreq_t bus_request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire [1:0] c   = interface_control_lines;
  wire       iso = bus_request.valid && bus_request.kind == `PLR_RT_ISO;
  // Opening only from idle also enforces the gap between transfers
  a_status_from_idle: assert property (c == 2'h1 && $past(c) != 2'h1 |-> $past(c) == 2'h0)
    else $error("status not from idle");
  a_status_length: assert property (c == 2'h1 [*8] |=> c != 2'h1)
    else $error("status too long");
  a_receive_aborts: assert property (rx_active && c == 2'h1 |=> c == 2'h2)
    else $error("status not cut by receive");
  a_iso_held: assert property (iso && !bus_won && !bus_reset |=> iso)
    else $error("iso request dropped");
  a_reset_clears: assert property (bus_reset |=> !bus_request.valid)
    else $error("request kept over bus reset");
  a_receive_drops: assert property (c == 2'h2 |=> !(bus_request.valid
    && bus_request.kind[2:1] == 2'h1))
    else $error("fair or priority kept in receive");
  a_ready_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout)
    else $error("no wait state");
  a_ready_pulse: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
endmodule // plr_port_checker
bind plr_port plr_port_checker i_chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout,
  .interface_control_lines, .rx_active, .bus_won, .bus_reset, .bus_request);

/* verif/plr_port_bench.sv */
`timescale 1ns/1ns
module plr_port_bench;
  import plr_pkg::*;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        rx_active = 1'h0, arb_reset_gap = 1'h0, subaction_gap = 1'h0;
  logic        bus_won = 1'h0, bus_lost = 1'h0, bus_reset = 1'h0, selfid_done = 1'h0;
  logic [1:0]  htrans = 2'h0, ctl, ctl_in, ctl_end;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [15:0] sw, sw_last;
  logic [7:0]  dl;
  logic        hreadyout, lrq, ctl_oe_n, acc, doe;
  logic        brp = 1'h0;
  plr_busreq_t breq;
  int          sn = 0, slen = 0, ndone = 0, miscompares = 0, checks = 0;
  always #50 hclk = ~hclk;
  plr_port i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .link_request_line(lrq), .ctl_in,
    .interface_control_lines(ctl), .ctl_oe_n, .interface_data_lines(dl), .data_oe_n(doe),
    .rx_active, .rx_data(8'h00), .bus_won, .bus_lost, .bus_reset, .bus_reset_pending(brp),
    .selfid_done, .arb_reset_gap, .subaction_gap, .phy_interrupt(1'h0),
    .bus_request(breq), .acceleration_feature_enable(acc));
  plr_link_model i_link (.hclk, .ctl_oe_n, .ctl_dev(ctl), .link_request_line(lrq), .ctl_in);
  // Bit 2k rides on line 0 and bit 2k+1 on line 1
  always @(posedge hclk)
    if (ctl === 2'h1) begin
      sw[2*sn+:2] <= dl[1:0];
      sn <= sn + 1;
    end else if (sn != 0) begin
      sw_last <= sw;
      ctl_end <= ctl;
      slen <= sn;
      ndone <= ndone + 1;
      sn <= 0;
    end
  task chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task req(input logic [16:0] v, input int n);
    i_link.send(v, n);
    @(posedge hclk);
  endtask
  task pulse(input logic [3:0] p);
    {selfid_done, bus_reset, bus_won, bus_lost} <= p;
    @(posedge hclk);
    {selfid_done, bus_reset, bus_won, bus_lost} <= 4'h0;
    @(posedge hclk);
  endtask
  task wst(input int n, input logic [15:0] e, m);
    int k;
    k = ndone;
    repeat (40) if (ndone == k) @(posedge hclk);
    chk("status length", slen, n);
    chk("status word", sw_last & m, e);
  endtask
  task report_and_stop;
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("accel", acc, 0);
    ahb(1'h1, 32'h54, 32'h1);
    ahb(1'h0, 32'h54, 0);
    chk("reg5", r, 1);
    chk("accel", acc, 1);
    ahb(1'h0, 32'h100, 0);
    chk("unmapped", r, 0);
    req({1'h1, 3'h5, 4'h6, 8'h3c, 1'h0}, 17);
    ahb(1'h0, 32'h58, 0);
    chk("reg6", r, 32'h3c);
    arb_reset_gap <= 1'h1;
    subaction_gap <= 1'h1;
    @(posedge hclk);
    arb_reset_gap <= 1'h0;
    subaction_gap <= 1'h0;
    wst(2, 16'h3, 16'hf);
    chk("end code", ctl_end, 2'h0);
    req({1'h1, 3'h4, 4'h6, 1'h0}, 9);
    wst(8, 16'h3c60, 16'hfff0);
    req({1'h1, 3'h4, 4'h6, 1'h0}, 9);
    repeat (20) if (ctl !== 2'h1) @(posedge hclk);
    rx_active <= 1'h1;
    repeat (3) @(posedge hclk);
    rx_active <= 1'h0;
    wst(8, 16'h3c60, 16'hfff0);
    req({1'h1, 3'h1, 3'h3, 1'h0}, 8);
    chk("req", breq, 7'h4b);
    req({1'h1, 3'h3, 3'h0, 1'h0}, 8);
    chk("req", {breq.valid, breq.kind}, 4'h9);
    req({1'h1, 3'h5, 4'h6, 8'h5a, 1'h0}, 17);
    ahb(1'h0, 32'h58, 0);
    chk("reg6", r, 32'h5a);
    pulse(4'h1);
    chk("req", {breq.valid, breq.kind}, 4'h9);
    req({1'h1, 3'h6, 1'h0, 1'h0}, 6);
    chk("accel", acc, 0);
    req({1'h1, 3'h6, 1'h1, 1'h0}, 6);
    chk("accel", acc, 1);
    req({1'h1, 3'h6, 1'h0, 1'h0}, 6);
    pulse(4'h4);
    chk("req", breq.valid, 0);
    chk("accel", acc, 1);
    wst(2, 16'h4, 16'hf);
    req({1'h1, 3'h6, 1'h0, 1'h0}, 6);
    req({1'h1, 3'h1, 3'h0, 1'h0}, 8);
    chk("accel", acc, 1);
    pulse(4'h2);
    chk("req", breq.valid, 0);
    repeat (8) @(posedge hclk);
    req({1'h1, 3'h3, 3'h4, 1'h0}, 8);
    chk("req", breq, 7'h5c);
    rx_active <= 1'h1;
    repeat (3) @(posedge hclk);
    chk("req", breq.valid, 0);
    req({1'h1, 3'h2, 3'h0, 1'h0}, 8);
    chk("req", breq.valid, 0);
    req({1'h1, 3'h0, 3'h0, 1'h0}, 8);
    chk("req", {breq.valid, breq.kind}, 4'h8);
    rx_active <= 1'h0;
    repeat (4) if (ctl !== 2'h3) @(posedge hclk);
    chk("grant", ctl, 2'h3);
    chk("drive", {ctl_oe_n, doe}, 2'h0);
    @(posedge hclk);
    chk("release", {ctl_oe_n, doe}, 2'h3);
    repeat (8) @(posedge hclk);
    rx_active <= 1'h1;
    req({1'h1, 3'h4, 4'h6, 1'h0}, 9);
    pulse(4'h4);
    rx_active <= 1'h0;
    wst(8, 16'h5a64, 16'hffff);
    req({1'h1, 3'h1, 3'h0, 1'h0}, 8);
    brp <= 1'h1;
    req({1'h1, 3'h4, 4'h6, 1'h0}, 9);
    repeat (20) if (ctl !== 2'h1) @(posedge hclk);
    pulse(4'h2);
    wst(8, 16'h5a60, 16'hffff);
    chk("end code", ctl_end, 2'h3);
    brp <= 1'h0;
    pulse(4'h8);
    wst(8, 16'h0, 16'hffff);
    report_and_stop;
  end
endmodule // plr_port_bench
